// File: hdl/uif_flags.sv
// Transmit-done and receive-done interrupt flags of the serial port
//Contract
// - 9-bit format: tx flag at stop start
// - Enabled tx flag requests port interrupt
// - Rx flag sits in control bit zero
// - Rx flag set at stop sampling
// - Enabled rx flag requests port interrupt
`timescale 1ns/10ps
module uif_flags
    import uif_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    input  wire uif_fmt_e          frame_fmt,
    input  wire uif_evt_s          frame_evt,
    input  wire uif_clr_s          sw_clr,
    input  wire logic              port_irq_en,
    output logic [SCON_W-1:0]      scon_flags,
    output logic                   tx_done_flag,
    output logic                   rx_done_flag,
    output logic                   port_irq_req
);

    // Flag state and next values
    logic                tx_done_flag_q;
    logic                tx_done_flag_d;
    logic                rx_done_flag_q;
    logic                rx_done_flag_d;

    // Decoded set and clear strobes
    logic                tx_set;
    logic                rx_set;
    logic                tx_clr;
    logic                rx_clr;

    // Interrupt request terms
    logic                tx_irq;
    logic                rx_irq;
    logic                irq_d;
    logic                irq_q;

    // Control register image
    logic [SCON_W-1:0]   scon_d;
    logic [SCON_W-1:0]   scon_q;

    // Transmit set strobe for the frame format
    function automatic logic tx_set_of(
        input uif_fmt_e fmt,
        input uif_evt_s evt
    );
        logic hit;

        hit = 1'b0;
        case (fmt)
            UIF_FMT_9BIT: begin
                hit = evt.stop_bit_start;
            end

            UIF_FMT_8BIT: begin
                // 8-bit frames finish after the last data bit
                hit = evt.last_data_bit;
            end

            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction : tx_set_of

    // Set beats clear so an event in the clear cycle is kept
    function automatic logic flag_next(
        input logic cur,
        input logic hit,
        input logic clr
    );
        logic nxt;

        nxt = cur;
        if (clr) begin
            nxt = 1'b0;
        end
        if (hit) begin
            nxt = 1'b1;
        end
        return nxt;
    endfunction : flag_next

    // Request term of one flag, gated by the port enable
    function automatic logic gate_req(
        input logic en,
        input logic flag
    );
        logic req;

        req = 1'b0;
        if (en) begin
            req = flag;
        end
        return req;
    endfunction : gate_req

    // Control image from the two flags; other bits hold reset
    function automatic logic [SCON_W-1:0] pack_flags(
        input logic rx,
        input logic tx
    );
        logic [SCON_W-1:0] img;

        img              = SCON_RESET;
        img[RX_DONE_BIT] = rx;
        img[TX_DONE_BIT] = tx;
        return img;
    endfunction : pack_flags

    // Transmit set follows the frame format
    always_comb begin
        tx_set = tx_set_of(frame_fmt, frame_evt);
    end

    // Receive set at stop bit sampling
    always_comb begin
        rx_set = 1'b0;
        if (frame_evt.stop_bit_sample) begin
            rx_set = 1'b1;
        end
    end

    // Only software clears; no hardware path does
    always_comb begin
        tx_clr = 1'b0;
        if (sw_clr.tx_done_clr) begin
            tx_clr = 1'b1;
        end
    end

    // Interrupt entry leaves the receive flag alone
    always_comb begin
        rx_clr = 1'b0;
        if (sw_clr.rx_done_clr) begin
            rx_clr = 1'b1;
        end
    end

    // Next transmit flag
    always_comb begin
        tx_done_flag_d = flag_next(tx_done_flag_q, tx_set, tx_clr);
    end

    // Next receive flag
    always_comb begin
        rx_done_flag_d = flag_next(rx_done_flag_q, rx_set, rx_clr);
    end

    // Transmit flag register
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            tx_done_flag_q <= SCON_RESET[TX_DONE_BIT];
        end else begin
            tx_done_flag_q <= tx_done_flag_d;
        end
    end

    // Receive flag register
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rx_done_flag_q <= SCON_RESET[RX_DONE_BIT];
        end else begin
            rx_done_flag_q <= rx_done_flag_d;
        end
    end

    // Terms from next values so the request rises with the flags
    always_comb begin
        tx_irq = gate_req(port_irq_en, tx_done_flag_d);
    end

    always_comb begin
        rx_irq = gate_req(port_irq_en, rx_done_flag_d);
    end

    // One shared vector for both flags
    always_comb begin
        irq_d = tx_irq | rx_irq;
    end

    // Registered request; drops a cycle after enable drops
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // Image from next values so it matches the flag registers
    always_comb begin
        scon_d = pack_flags(rx_done_flag_d, tx_done_flag_d);
    end

    // Control image register
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            scon_q <= SCON_RESET;
        end else begin
            scon_q <= scon_d;
        end
    end

    // Outputs straight from flip-flops
    assign scon_flags   = scon_q;
    assign tx_done_flag = tx_done_flag_q;
    assign rx_done_flag = rx_done_flag_q;
    assign port_irq_req = irq_q;
endmodule : uif_flags

// File: hdl/uif_pkg.sv
// Package for the serial port interrupt flag block
package uif_pkg;
    localparam int SCON_W        = 8;
    localparam int RX_DONE_BIT   = 0;
    localparam int TX_DONE_BIT   = 1;
    localparam logic [SCON_W-1:0] SCON_RESET = 8'h00;

    typedef enum logic {
        UIF_FMT_8BIT,
        UIF_FMT_9BIT
    } uif_fmt_e;

    // Frame timing strobes from the shift logic
    typedef struct packed {
        logic last_data_bit;
        logic stop_bit_start;
        logic stop_bit_sample;
    } uif_evt_s;

    // Software clear requests, one per flag
    typedef struct packed {
        logic tx_done_clr;
        logic rx_done_clr;
    } uif_clr_s;
endpackage : uif_pkg

// File: testbench/uif_flags_monitor.sv
// Flag checker
`timescale 1ns/10ps
module uif_mon import uif_pkg::*;(input wire logic sys_clk,reset_n,
 port_irq_en,tx_done_flag,rx_done_flag,port_irq_req,
 input wire uif_fmt_e frame_fmt,input wire uif_evt_s frame_evt,
 input wire uif_clr_s sw_clr);
default clocking @(posedge sys_clk);endclocking
default disable iff(!reset_n);
tx_set_a:assert property(frame_fmt&&frame_evt[1]|=>tx_done_flag)
 else $error("tx");
rx_set_a:assert property(frame_evt[0]|=>rx_done_flag)
 else $error("rx");
irq_req_a:assert property($past(port_irq_en)
 &&(tx_done_flag||rx_done_flag)|->port_irq_req)else $error("ir");
tx_fmt8_a:assert property(frame_fmt==UIF_FMT_8BIT&&frame_evt[2]
 |=>tx_done_flag)else $error("tx8");
tx_hold_a:assert property(tx_done_flag&&!sw_clr.tx_done_clr
 |=>tx_done_flag)else $error("tx hold");
rx_hold_a:assert property(rx_done_flag&&!sw_clr.rx_done_clr
 |=>rx_done_flag)else $error("rx hold");
cover property(port_irq_req);
cover property(tx_done_flag);
cover property(rx_done_flag);
endmodule:uif_mon
bind uif_flags uif_mon mon(.*);

// File: testbench/uif_sw_model.sv
// Software model
`timescale 1ns/10ps
module uif_sw import uif_pkg::*;(input wire logic serve,
 input wire logic [7:0] scon_flags,output uif_clr_s sw_clr);
assign sw_clr=serve?scon_flags[1:0]:'0;
endmodule:uif_sw

// File: testbench/uif_flags_tb.sv
// Bench
`timescale 1ns/10ps
module uif_flags_tb import uif_pkg::*;;
logic k=0,n=0,p=1,b=0,f=0,q,tf,rf;
logic [2:0] v=0;
logic [1:0] w;
logic [7:0] s;
int mismatches=0,checks_done=0;
logic [5:0] r[4]='{6'h2F,6'h30,6'h12,6'h08};
always #4 k=~k;
uif_flags dut(.sys_clk(k),.reset_n(n),.frame_fmt(uif_fmt_e'(f)),
 .frame_evt(v),.sw_clr(w),.port_irq_en(p),.scon_flags(s),
 .tx_done_flag(tf),.rx_done_flag(rf),.port_irq_req(q));
uif_sw sw(.serve(b),.scon_flags(s),.sw_clr(w));
task t(int i);repeat(i)@(negedge k);endtask:t
task c(logic [8:0] g,e);checks_done++;
 if(g!==e)begin mismatches++;$display("Error %0t %h %h",$time,g,e);end
endtask:c
task close_out;$display("%0d %0d",mismatches,checks_done);
 if(!mismatches&&checks_done)$display("Testbench passed");
 else $display("Testbench failed");
 $finish;endtask:close_out
initial begin t(16);n=1;
 foreach(r[i])begin f=r[i][5];v=r[i][4:2];t(1);v=0;t(1);
  c({q,s},{|r[i][1:0],6'h0,r[i][1:0]});
  c({tf,rf},{7'h0,r[i][1:0]});
  b=1;t(2);b=0;c({q,s},9'h0);$display("row %0d",i);end
 p=0;v=1;t(1);v=0;t(3);c({q,s},9'h1);
 c({tf,rf},9'h1);$display("no enable done");
 n=0;t(2);c({q,s},9'h0);
 n=1;t(2);c({tf,rf},9'h0);$display("reset done");close_out;end
initial begin t(999);mismatches++;close_out;end
endmodule:uif_flags_tb
